/* File: design/bvpt_cb_if.sv */
/*
 * Carries one decoded command wrapper from the parser to the pin test port.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface bvpt_cb_if;
   logic        done;
   logic [7:0]  marker;
   logic [7:0]  sub;
   logic [31:0] len;
   logic        dir_in;
   modport src (output done, output marker, output sub, output len, output dir_in);
   modport dst (input done, input marker, input sub, input len, input dir_in);
endinterface
`default_nettype wire

/* File: design/bvpt_cbw_parse.sv */
/*
 * Parses the 31-byte command wrapper stream into the fields the port needs.
 * Assumes bytes arrive in order, the first marked by a start strobe.
 */
`timescale 1ns/1ps
`default_nettype none
module bvpt_cbw_parse
   import bvpt_pkg::*;
(
   input  wire logic       clk_in,
   input  wire logic       rst_in,
   input  wire logic       ce_in,
   input  wire logic       cbw_start_in,
   input  wire logic       cbw_valid_in,
   input  wire logic [7:0] cbw_byte_in,
   bvpt_cb_if.src          cb
);
   logic [4:0]  idx;
   logic [4:0]  next_idx;
   logic [4:0]  bidx;
   logic        next_done;
   logic [7:0]  next_marker;
   logic [7:0]  next_sub;
   logic [31:0] next_len;
   logic        next_dir;

   always_comb begin
      bidx        = cbw_start_in ? 5'h00 : idx;
      next_idx    = idx;
      next_done   = 1'b0;
      next_marker = cb.marker;
      next_sub    = cb.sub;
      next_len    = cb.len;
      next_dir    = cb.dir_in;
      if (cbw_valid_in && bidx != CBW_IDLE_IDX) begin
         next_idx = bidx + 5'h01;
         if (bidx >= CBW_LEN_LO && bidx <= CBW_LEN_HI) begin
            next_len[{bidx[1:0], 3'b000} +: 8] = cbw_byte_in;
         end
         if (bidx == CBW_FLAGS) begin
            next_dir = cbw_byte_in[DIR_BIT];
         end
         if (bidx == CB_BYTE0) begin
            next_marker = cbw_byte_in;
         end
         if (bidx == CB_BYTE1) begin
            next_sub = cbw_byte_in;
         end
         if (bidx == CBW_LAST) begin
            next_done = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         idx       <= CBW_IDLE_IDX;
         cb.done   <= 1'b0;
         cb.marker <= 8'h00;
         cb.sub    <= 8'h00;
         cb.len    <= 32'h0000_0000;
         cb.dir_in <= 1'b0;
      end else if (ce_in) begin
         idx       <= next_idx;
         cb.done   <= next_done;
         cb.marker <= next_marker;
         cb.sub    <= next_sub;
         cb.len    <= next_len;
         cb.dir_in <= next_dir;
      end
   end
endmodule
`default_nettype wire

/* File: design/bvpt_pkg.sv */
/*
 * Shared constants for the vendor command block decoder and the pin test port.
 * Assumes byte-wide command wrapper and data streams on the core clock.
 */
package bvpt_pkg;
   localparam int          LEN_W        = 32;
   localparam logic [7:0]  SUB_EEPROM   = 8'h26;
   localparam logic [7:0]  SUB_PIN_TEST = 8'h27;
   localparam logic [4:0]  CBW_LEN_LO   = 5'h08;
   localparam logic [4:0]  CBW_LEN_HI   = 5'h0b;
   localparam logic [4:0]  CBW_FLAGS    = 5'h0c;
   localparam int          DIR_BIT      = 7;
   localparam logic [4:0]  CB_BYTE0     = 5'h0f;
   localparam logic [4:0]  CB_BYTE1     = 5'h10;
   localparam logic [4:0]  CBW_LAST     = 5'h1e;
   localparam logic [4:0]  CBW_IDLE_IDX = 5'h1f;
   localparam logic [31:0] PIN_BYTES    = 32'h0000_0004;
   localparam int          P_RST        = 7;
   localparam int          P_CS         = 4;
   localparam int          P_PWR        = 3;
   localparam int          P_ADL        = 1;
   localparam int          P_DDOE       = 15;
   localparam int          P_DACK       = 10;
   localparam int          P_RD         = 9;
   localparam int          P_WR         = 8;
   localparam int          P_DBUS       = 16;
   localparam logic [31:0] PIN_RST_VAL  = 32'h0000_07b0;
   localparam logic [1:0]  STRAP_WAIT   = 2'h3;
   localparam int          SYNC_W       = 20;
endpackage

/* File: design/bvpt_top.sv */
/*
 * Vendor command block decoder with EEPROM request hand-off and the board pin test port.
 * Assumes the bridge supplies normal pin control and wrapper bytes on the core clock.
 */
`timescale 1ns/1ps
`default_nettype none
module bvpt_top
   import bvpt_pkg::*;
(
   input  wire logic                       clk_in,
   input  wire logic                       rst_in,
   input  wire logic                       ce_in,
   input  wire logic                       cbw_start_in,
   input  wire logic                       cbw_valid_in,
   input  wire logic [7:0]                 cbw_byte_in,
   input  wire logic [7:0]                 vendor_marker_in,
   input  wire logic                       eeprom_sig_bad_in,
   input  wire logic                       host_data_valid_in,
   input  wire logic [7:0]                 host_data_in,
   input  wire logic                       dev_data_ready_in,
   output logic                            dev_data_valid_out,
   output logic [7:0]                      dev_data_out,
   output logic                            eep_start_out,
   output logic                            eep_read_out,
   output logic [bvpt_pkg::LEN_W-1:0]      eep_len_out,
   output logic                            cmd_unrec_out,
   output logic                            xfer_done_out,
   output logic                            boot_mfg_out,
   output logic                            test_mode_out,
   input  wire logic                       norm_reset_n_in,
   input  wire logic                       norm_addr2_in,
   input  wire logic [1:0]                 norm_cs_n_in,
   input  wire logic                       norm_pwr_valid_in,
   input  wire logic [1:0]                 norm_addr_low_in,
   input  wire logic                       norm_dma_ack_n_in,
   input  wire logic                       norm_rd_n_in,
   input  wire logic                       norm_wr_n_in,
   input  wire logic [15:0]                norm_data_in,
   input  wire logic                       norm_data_oe_in,
   input  wire logic                       norm_bus_power_en_in,
   output logic [15:0]                     data_bus_sync_out,
   input  wire logic                       drive_reset_n_in,
   output logic                            drive_reset_n_out,
   output logic                            drive_reset_n_oe_out,
   output logic                            drive_reg_addr_bit2_out,
   output logic [1:0]                      drive_cs_n_out,
   output logic                            drive_power_valid_out,
   output logic [1:0]                      drive_reg_addr_low_out,
   output logic                            drive_dma_ack_n_out,
   output logic                            drive_read_strobe_n_out,
   output logic                            drive_write_strobe_n_out,
   output logic                            bus_power_drive_en_out,
   input  wire logic                       drive_irq_in,
   input  wire logic                       drive_dma_request_in,
   input  wire logic                       drive_io_ready_in,
   input  wire logic [15:0]                drive_data_bus_in,
   output logic [15:0]                     drive_data_bus_out,
   output logic                            drive_data_bus_oe_out
);
   typedef enum logic [1:0] {st_idle, st_pin_load, st_pin_read} bvpt_state_t;

   bvpt_cb_if cb ();

   bvpt_cbw_parse u_parse (
      .clk_in       (clk_in),
      .rst_in       (rst_in),
      .ce_in        (ce_in),
      .cbw_start_in (cbw_start_in),
      .cbw_valid_in (cbw_valid_in),
      .cbw_byte_in  (cbw_byte_in),
      .cb           (cb)
   );

   logic [SYNC_W-1:0] sync_q1;
   logic [SYNC_W-1:0] sync_q2;
   logic              rst_n_s;
   logic              irq_s;
   logic              dma_req_s;
   logic              io_ready_s;
   logic [15:0]       data_bus_s;

   // Pins are asynchronous to the core clock, so two stages come before any reader.
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         sync_q1 <= '0;
         sync_q2 <= '0;
      end else if (ce_in) begin
         sync_q1 <= {drive_reset_n_in, drive_irq_in, drive_dma_request_in, drive_io_ready_in, drive_data_bus_in};
         sync_q2 <= sync_q1;
      end
   end
   assign {rst_n_s, irq_s, dma_req_s, io_ready_s, data_bus_s} = sync_q2;

   bvpt_state_t state;
   bvpt_state_t next_state;
   logic [31:0] idx;
   logic [31:0] next_idx;
   logic [31:0] pin_reg;
   logic [31:0] next_pin_reg;
   logic [31:0] snap;
   logic [31:0] next_snap;
   logic [31:0] live;
   logic [1:0]  strap_cnt;
   logic [1:0]  next_strap_cnt;
   logic        strap_done;
   logic        match;
   logic        next_boot, next_test, next_dv, next_eep_start, next_eep_read, next_unrec, next_done;
   logic [7:0]  next_dout;
   logic [31:0] next_eep_len;
   logic        next_rst_n, next_rst_oe, next_addr2, next_pwr, next_dack, next_rd, next_wr, next_bpwr, next_dbus_oe;
   logic [1:0]  next_cs, next_adl;
   logic [15:0] next_dbus;

   function automatic logic [7:0] snap_byte(input logic [31:0] s, input logic [31:0] i);
      snap_byte = (i < PIN_BYTES) ? s[{i[1:0], 3'b000} +: 8] : 8'h00;
   endfunction

   always_comb begin
      strap_done = (strap_cnt == STRAP_WAIT);
      match      = (cb.marker == vendor_marker_in);
      // Read-only bits, reset and the data bus report the pins as they stand; bit 15 reads 0; other loadable bits report what is driven.
      live = {data_bus_s[15:8], data_bus_s[7:0],
              1'b0, test_mode_out, bus_power_drive_en_out, dma_req_s, io_ready_s,
              drive_dma_ack_n_out, drive_read_strobe_n_out, drive_write_strobe_n_out,
              rst_n_s, drive_reg_addr_bit2_out, drive_cs_n_out, drive_power_valid_out,
              drive_reg_addr_low_out, irq_s};
      next_strap_cnt = strap_done ? strap_cnt : strap_cnt + 2'h1;
      next_boot      = boot_mfg_out | eeprom_sig_bad_in;
      if (next_strap_cnt == STRAP_WAIT && !strap_done && !rst_n_s) begin
         next_boot = 1'b1;
      end
      next_state     = state;
      next_idx       = idx;
      next_pin_reg   = pin_reg;
      next_snap      = snap;
      next_test      = test_mode_out;
      next_dv        = dev_data_valid_out;
      next_dout      = dev_data_out;
      next_eep_start = 1'b0;
      next_eep_read  = eep_read_out;
      next_eep_len   = eep_len_out;
      next_unrec     = 1'b0;
      next_done      = 1'b0;
      unique case (state)
         st_idle: begin
            if (cb.done) begin
               if (match && boot_mfg_out && cb.sub == SUB_EEPROM) begin
                  next_eep_start = 1'b1;
                  next_eep_read  = cb.dir_in;
                  next_eep_len   = cb.len;
               end else if (match && boot_mfg_out && cb.sub == SUB_PIN_TEST) begin
                  next_idx = 32'h0000_0000;
                  if (cb.dir_in) begin
                     next_snap = live;
                     if (cb.len != 32'h0000_0000) begin
                        next_state = st_pin_read;
                        next_dv    = 1'b1;
                        next_dout  = snap_byte(live, 32'h0000_0000);
                     end else begin
                        next_done = 1'b1;
                     end
                  end else begin
                     next_test = 1'b1;
                     if (cb.len != 32'h0000_0000) begin
                        next_state = st_pin_load;
                     end else begin
                        next_done = 1'b1;
                     end
                  end
               end else begin
                  next_unrec = 1'b1;
               end
            end
         end
         st_pin_load: begin
            if (host_data_valid_in) begin
               if (idx < PIN_BYTES) begin
                  next_pin_reg[{idx[1:0], 3'b000} +: 8] = host_data_in;
               end
               next_idx = idx + 32'h0000_0001;
               if (next_idx == cb.len) begin
                  next_state = st_idle;
                  next_done  = 1'b1;
               end
            end
         end
         st_pin_read: begin
            if (dev_data_ready_in) begin
               next_idx = idx + 32'h0000_0001;
               if (next_idx == cb.len) begin
                  next_state = st_idle;
                  next_dv    = 1'b0;
                  next_done  = 1'b1;
               end else begin
                  next_dout = snap_byte(snap, next_idx);
               end
            end
         end
      endcase
      // The packet owns every non-USB output once test mode is on, except address bit 2, bus power enable and the reset output enable.
      next_rst_oe = strap_done;
      next_rst_n  = test_mode_out ? pin_reg[P_RST] : norm_reset_n_in;
      next_addr2  = norm_addr2_in;
      next_cs     = test_mode_out ? pin_reg[P_CS +: 2] : norm_cs_n_in;
      next_pwr    = test_mode_out ? pin_reg[P_PWR] : norm_pwr_valid_in;
      next_adl    = test_mode_out ? pin_reg[P_ADL +: 2] : norm_addr_low_in;
      next_dack   = test_mode_out ? pin_reg[P_DACK] : norm_dma_ack_n_in;
      next_rd     = test_mode_out ? pin_reg[P_RD] : norm_rd_n_in;
      next_wr     = test_mode_out ? pin_reg[P_WR] : norm_wr_n_in;
      next_bpwr   = norm_bus_power_en_in;
      next_dbus    = test_mode_out ? pin_reg[P_DBUS +: 16] : norm_data_in;
      next_dbus_oe = test_mode_out ? pin_reg[P_DDOE] : norm_data_oe_in;
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         state                    <= st_idle;
         idx                      <= 32'h0000_0000;
         pin_reg                  <= PIN_RST_VAL;
         snap                     <= 32'h0000_0000;
         strap_cnt                <= 2'h0;
         boot_mfg_out             <= 1'b0;
         test_mode_out            <= 1'b0;
         dev_data_valid_out       <= 1'b0;
         dev_data_out             <= 8'h00;
         eep_start_out            <= 1'b0;
         eep_read_out             <= 1'b0;
         eep_len_out              <= 32'h0000_0000;
         cmd_unrec_out            <= 1'b0;
         xfer_done_out            <= 1'b0;
         data_bus_sync_out        <= 16'h0000;
         drive_reset_n_out        <= 1'b1;
         drive_reset_n_oe_out     <= 1'b0;
         drive_reg_addr_bit2_out  <= 1'b0;
         drive_cs_n_out           <= 2'h3;
         drive_power_valid_out    <= 1'b0;
         drive_reg_addr_low_out   <= 2'h0;
         drive_dma_ack_n_out      <= 1'b1;
         drive_read_strobe_n_out  <= 1'b1;
         drive_write_strobe_n_out <= 1'b1;
         bus_power_drive_en_out   <= 1'b0;
         drive_data_bus_out       <= 16'h0000;
         drive_data_bus_oe_out    <= 1'b0;
      end else if (ce_in) begin
         state                    <= next_state;
         idx                      <= next_idx;
         pin_reg                  <= next_pin_reg;
         snap                     <= next_snap;
         strap_cnt                <= next_strap_cnt;
         boot_mfg_out             <= next_boot;
         test_mode_out            <= next_test;
         dev_data_valid_out       <= next_dv;
         dev_data_out             <= next_dout;
         eep_start_out            <= next_eep_start;
         eep_read_out             <= next_eep_read;
         eep_len_out              <= next_eep_len;
         cmd_unrec_out            <= next_unrec;
         xfer_done_out            <= next_done;
         data_bus_sync_out        <= data_bus_s;
         drive_reset_n_out        <= next_rst_n;
         drive_reset_n_oe_out     <= next_rst_oe;
         drive_reg_addr_bit2_out  <= next_addr2;
         drive_cs_n_out           <= next_cs;
         drive_power_valid_out    <= next_pwr;
         drive_reg_addr_low_out   <= next_adl;
         drive_dma_ack_n_out      <= next_dack;
         drive_read_strobe_n_out  <= next_rd;
         drive_write_strobe_n_out <= next_wr;
         bus_power_drive_en_out   <= next_bpwr;
         drive_data_bus_out       <= next_dbus;
         drive_data_bus_oe_out    <= next_dbus_oe;
      end
   end

   default clocking cb_clk @(posedge clk_in); endclocking
   default disable iff (rst_in);

   sequence vendor_ok_s;
      ce_in && state == st_idle && cb.done && match && boot_mfg_out;
   endsequence
   sequence pin_load_go_s;
      vendor_ok_s and (cb.sub == SUB_PIN_TEST && !cb.dir_in && cb.len != 32'h0000_0000);
   endsequence
   sequence eep_go_s;
      vendor_ok_s and (cb.sub == SUB_EEPROM);
   endsequence

   marker_mismatch_a: assert property (ce_in && state == st_idle && cb.done && !match |=> cmd_unrec_out && !eep_start_out)
      else $error("Block with wrong marker was not refused.");
   eep_request_a: assert property (eep_go_s |=> eep_start_out && !cmd_unrec_out)
      else $error("EEPROM block did not raise the request.");
   eep_length_a: assert property (eep_go_s |=> eep_len_out == $past(cb.len))
      else $error("EEPROM length not taken from the wrapper.");
   eep_direction_a: assert property (eep_go_s |=> eep_read_out == $past(cb.dir_in))
      else $error("EEPROM direction not taken from the wrapper.");
   load_enters_test_a: assert property (pin_load_go_s |=> state == st_pin_load && test_mode_out)
      else $error("Pin test load did not enter test mode.");
   test_mode_sticky_a: assert property (test_mode_out |=> test_mode_out)
      else $error("Test mode left without a reset.");
   pins_hold_a: assert property (!(state == st_pin_load && host_data_valid_in && idx < PIN_BYTES) |=> $stable(pin_reg))
      else $error("Pin states changed outside a load.");
   mode_report_a: assert property (dev_data_valid_out && idx == 32'h0000_0001 |-> dev_data_out[6] == test_mode_out)
      else $error("Byte 1 bit 6 does not report test mode.");
   not_boot_refused_a: assert property (ce_in && state == st_idle && cb.done && !boot_mfg_out |=> cmd_unrec_out[*1] ##1 !eep_start_out)
      else $error("Vendor block honoured outside manufacturing mode.");
   test_drives_pins_a: assert property (ce_in && test_mode_out |=> drive_data_bus_oe_out == $past(pin_reg[P_DDOE]))
      else $error("Data bus enable not taken from the packet.");
endmodule
`default_nettype wire

/* File: test/bvpt_host.sv */
/* Host model: sends one 31-byte command wrapper per request.
   Assumes the bench raises send_in for one cycle only while busy_out is low. */
`timescale 1ns/1ps
`default_nettype none
module bvpt_host (
   input  wire logic        clk_in,
   input  wire logic        send_in,
   input  wire logic [7:0]  marker_in,
   input  wire logic [7:0]  sub_in,
   input  wire logic [31:0] len_in,
   input  wire logic        rd_in,
   output logic             busy_out,
   output logic             start_out,
   output logic             valid_out,
   output logic [7:0]       byte_out
);
   logic [7:0] w [31];
   initial begin
      {busy_out, start_out, valid_out, byte_out} = '0;
      forever begin
         @(posedge clk_in);
         if (send_in) begin
            busy_out = 1'b1;
            foreach (w[i]) w[i] = 8'h00;
            {w[11], w[10], w[9], w[8]} = len_in;
            w[12] = {rd_in, 7'h00};
            w[14] = 8'h10;
            w[15] = marker_in;
            w[16] = sub_in;
            if (sub_in == 8'h26) w[18] = 8'h02;
            for (int i = 0; i < 31; i++) begin
               @(negedge clk_in);
               start_out = (i == 0);
               valid_out = 1'b1;
               byte_out = w[i];
            end
            @(negedge clk_in);
            start_out = 1'b0;
            valid_out = 1'b0;
            // A released line must not keep its last byte, or stale data could pass.
            byte_out = ~byte_out;
            busy_out = 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

/* File: test/testbench.sv */
/* Self-checking bench for the pin test port, driving wrappers through the host model.
   Assumes a 20 MHz core clock and inputs changed on the falling edge. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import bvpt_pkg::*;
   logic        clk_in, rst_in, strap, send, rd, hv, rdy, sb, st, cv, bsy;
   logic        dv, es, er, cu, xd, bm, tm, ro, roe, pw, dk, rs, ws, doe;
   logic        ce, nrst, na2, npw, ndk, nrd, nwr, noe, nbp, irq, dmq, io_rdy, a2, bp;
   logic [7:0]  mk, sub, hd, cb, dbyte, vm;
   logic [31:0] len, el;
   logic [1:0]  cs, al, ncs, nal;
   logic [15:0] dbo, nd, dsync;
   int          mismatches, total_checks, n_eep, n_unrec, n_done, n;
   logic [7:0]  pk [6] = '{8'haa, 8'h85, 8'h5a, 8'hc3, 8'h11, 8'h22};
   logic [7:0]  rx [5] = '{8'heb, 8'h6d, 8'h5a, 8'hc3, 8'h00};
   wire logic        rpin = roe ? ro : strap;
   wire logic [15:0] dbus = doe ? dbo : 16'h1234;
   bvpt_host host (.clk_in(clk_in), .send_in(send), .marker_in(mk), .sub_in(sub), .len_in(len), .rd_in(rd),
      .busy_out(bsy), .start_out(st), .valid_out(cv), .byte_out(cb));
   bvpt_top dut (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce), .cbw_start_in(st), .cbw_valid_in(cv),
      .cbw_byte_in(cb), .vendor_marker_in(vm), .eeprom_sig_bad_in(sb), .host_data_valid_in(hv),
      .host_data_in(hd), .dev_data_ready_in(rdy), .dev_data_valid_out(dv), .dev_data_out(dbyte),
      .eep_start_out(es), .eep_read_out(er), .eep_len_out(el), .cmd_unrec_out(cu), .xfer_done_out(xd),
      .boot_mfg_out(bm), .test_mode_out(tm), .norm_reset_n_in(nrst), .norm_addr2_in(na2),
      .norm_cs_n_in(ncs), .norm_pwr_valid_in(npw), .norm_addr_low_in(nal), .norm_dma_ack_n_in(ndk),
      .norm_rd_n_in(nrd), .norm_wr_n_in(nwr), .norm_data_in(nd), .norm_data_oe_in(noe),
      .norm_bus_power_en_in(nbp), .data_bus_sync_out(dsync), .drive_reset_n_in(rpin), .drive_reset_n_out(ro),
      .drive_reset_n_oe_out(roe), .drive_reg_addr_bit2_out(a2), .drive_cs_n_out(cs), .drive_power_valid_out(pw),
      .drive_reg_addr_low_out(al), .drive_dma_ack_n_out(dk), .drive_read_strobe_n_out(rs),
      .drive_write_strobe_n_out(ws), .bus_power_drive_en_out(bp), .drive_irq_in(irq),
      .drive_dma_request_in(dmq), .drive_io_ready_in(io_rdy), .drive_data_bus_in(dbus),
      .drive_data_bus_out(dbo), .drive_data_bus_oe_out(doe));
   initial begin
      clk_in = 1'b0;
      forever #25 clk_in = ~clk_in;
   end
   always @(posedge clk_in) begin
      if (es === 1'b1) n_eep++;
      if (cu === 1'b1) n_unrec++;
      if (xd === 1'b1) n_done++;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int k);
      repeat (k) @(negedge clk_in);
   endtask
   // Ready is pulsed for one cycle per byte so that no byte slips past unseen.
   task automatic take(input logic [7:0] exp);
      n = 0;
      while (dv !== 1'b1 && n < 20) begin
         cyc(1);
         n++;
      end
      chk(dv, 1'b1);
      chk(dbyte, exp);
      rdy = 1'b1;
      cyc(1);
      rdy = 1'b0;
      cyc(1);
   endtask
   task automatic reset_dut;
      rst_in = 1'b1;
      cyc(16);
      rst_in = 1'b0;
      cyc(8);
   endtask
   // Pulses are counted rather than waited for, so a late or doubled pulse still shows.
   task automatic wrap(input logic [7:0] m, input logic [7:0] s, input logic [31:0] l, input logic r);
      mk = m;
      sub = s;
      len = l;
      rd = r;
      send = 1'b1;
      cyc(1);
      send = 1'b0;
      cyc(1);
      while (bsy) cyc(1);
      cyc(3);
   endtask
   task automatic pins;
      chk({ro, cs, pw, al, doe, dk, rs, ws}, 32'h0000_035d);
      chk(dbo, 16'hc35a);
      chk(tm, 1'b1);
      chk({a2, bp, roe}, 3'b111);
      chk(dsync, 16'hc35a);
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      #200_000;
      mismatches++;
      end_sim;
   end
   initial begin
      {strap, send, rd, hv, rdy, sb, mk, sub, hd, len} = '0;
      {ce, nrst, na2, npw, ndk, nrd, nwr, noe, nbp, irq, dmq, io_rdy} = 12'ha4d;
      {vm, ncs, nal, nd} = {8'h24, 2'b01, 2'b10, 16'h3ca5};
      strap = 1'b1;
      reset_dut;
      chk(bm, 1'b0);
      wrap(8'h24, 8'h27, 32'h4, 1'b0);
      chk(n_unrec, 1);
      chk(tm, 1'b0);
      // With the clock enable low a bad signature must leave no trace.
      ce = 1'b0;
      sb = 1'b1;
      cyc(1);
      ce = 1'b1;
      sb = 1'b0;
      cyc(2);
      chk(bm, 1'b0);
      sb = 1'b1;
      cyc(1);
      sb = 1'b0;
      cyc(2);
      chk(bm, 1'b1);
      strap = 1'b0;
      reset_dut;
      strap = 1'b1;
      chk(bm, 1'b1);
      chk(cs, 2'b01);
      chk({a2, bp, roe, ro}, 4'b1110);
      chk(dsync, 16'h1234);
      wrap(8'h25, 8'h27, 32'h4, 1'b0);
      chk(n_unrec, 2);
      wrap(8'h24, 8'h28, 32'h4, 1'b0);
      chk(n_unrec, 3);
      wrap(8'h24, 8'h26, 32'hff, 1'b1);
      chk(n_eep, 1);
      chk(er, 1'b1);
      chk(el, 32'hff);
      vm = 8'h5c;
      wrap(8'h5c, 8'h26, 32'h10, 1'b0);
      vm = 8'h24;
      chk(n_eep, 2);
      chk(er, 1'b0);
      chk(el, 32'h10);
      wrap(8'h24, 8'h27, 32'h2, 1'b1);
      take(8'h55);
      take(8'h2a);
      wrap(8'h24, 8'h27, 32'h6, 1'b0);
      foreach (pk[i]) begin
         hv = 1'b1;
         hd = pk[i];
         cyc(1);
      end
      hv = 1'b0;
      cyc(3);
      chk(n_done, 2);
      pins;
      wrap(8'h24, 8'h27, 32'h5, 1'b1);
      foreach (rx[i]) take(rx[i]);
      cyc(3);
      chk(dv, 1'b0);
      chk(n_done, 3);
      pins;
      end_sim;
   end
endmodule
`default_nettype wire
